// File: logic/sgd_defs.vh
// constants for the sideband glitch and drive control block
// Notes on behaviour
// - glitch-once command makes exactly one pulse on enabled signals, then idle
// - every pulse lasts pulse multiplier times pulse length count
// - each new glitch-once command starts another pulse without a stop
// - glitch-cycle command repeats pulses until a stop command
// - gap between cycle pulses is gap multiplier times gap length count, plus two clock cycles
// - pseudo-random command emits random pulses until a stop command
// - ratio N glitches one part in N on average; 2 is half, up to 511
// - each drivable line has open and closed drive settings: none, high, low
// - both settings reset to none; none means only switch, never drive
// - only six lines can be driven: two resets, dual port, hot plugs, power disable
// - push-pull lines drive device side high or low; host side never driven
// - open-drain lines: low pulls device side low, high leaves it undriven
// - a glitch into open state with active open setting drives that level instead
// - present line levels are readable separately on host and device side
// - each trigger port mirrors one selected line live; two at most
// - mirroring starts only once the port is in sideband-monitor mode
// - a glitch inverts the present switch state for the pulse duration
// - per-line glitch enable, reset off; pulses only touch enabled lines
`ifndef SGD_DEFS_VH
`define SGD_DEFS_VH

`define SGD_CLK_KHZ        20000
`define SGD_T_1US_NS       1000
`define SGD_T_10US_NS      10000
`define SGD_T_100US_NS     100000
`define SGD_T_1MS_NS       1000000
`define SGD_CYC(t)         (((t) * `SGD_CLK_KHZ) / 1000000)

`define SGD_NLINES         6
`define SGD_PUSHPULL_MASK  6'h23

`define SGD_ADR_CMD        8'h00
`define SGD_ADR_PULSE      8'h04
`define SGD_ADR_GAP        8'h08
`define SGD_ADR_RATIO      8'h0c
`define SGD_ADR_GLEN       8'h10
`define SGD_ADR_DRIVE      8'h14
`define SGD_ADR_TRIG       8'h18
`define SGD_ADR_MON        8'h1c

`define SGD_CMD_NONE       3'h0
`define SGD_CMD_ONCE       3'h1
`define SGD_CMD_CYCLE      3'h2
`define SGD_CMD_PRBS       3'h3
`define SGD_CMD_OFF        3'h4

`define SGD_DRV_NONE       2'h0
`define SGD_DRV_HIGH       2'h1
`define SGD_DRV_LOW        2'h2

`define SGD_LEN_MSB        15
`define SGD_MULT_LSB       16
`define SGD_MULT_MSB       17
`define SGD_DRV_CLOSED_LSB 12
`define SGD_TRIG_IN_LSB    8
`define SGD_MON_DEV_LSB    8
`define SGD_MON_TIN_BIT    16

`define SGD_RST_PULSE      18'h0_0001
`define SGD_RST_GAP        18'h0_0001
`define SGD_RST_RATIO      9'h002
`define SGD_RST_DRIVE      24'h00_0000
`define SGD_LFSR_SEED      16'hace1

`endif

// File: logic/sgd_timer.v
// tick prescaler and length down-counter for pulse, gap and slot timing
`timescale 1ns/1ps
`default_nettype none
`include "sgd_defs.vh"
module sgd_timer #(
	parameter [14:0] TICK_1MS_CYC = 15'd20000
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        load_i,
	input  wire [1:0]  mult_i,
	input  wire [15:0] len_i,
	output reg         done_o
);
	reg  [14:0] pre;
	reg  [14:0] reload;
	reg  [15:0] cnt;
	reg         run;

	// tick period in clock cycles for each multiplier code
	function [14:0] tick_len;
		input [1:0]  m;
		reg   [31:0] ncyc;
		begin
			case (m)
				2'h0:    ncyc = `SGD_CYC(`SGD_T_1US_NS);
				2'h1:    ncyc = `SGD_CYC(`SGD_T_10US_NS);
				2'h2:    ncyc = `SGD_CYC(`SGD_T_100US_NS);
				default: ncyc = {17'h00000, TICK_1MS_CYC};
			endcase
			tick_len = ncyc[14:0];
		end
	endfunction

	always @(posedge clk_i) begin
		if (rst_i) begin
			pre    <= 15'h0000;
			reload <= 15'h0000;
			cnt    <= 16'h0000;
			run    <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (load_i) begin
				reload <= tick_len(mult_i) - 15'h0001;
				pre    <= tick_len(mult_i) - 15'h0001;
				cnt    <= len_i;
				run    <= (len_i != 16'h0000);
				done_o <= (len_i == 16'h0000);
			end else if (run) begin
				if (pre == 15'h0000) begin
					pre <= reload;
					cnt <= cnt - 16'h0001;
					if (cnt == 16'h0001) begin
						run    <= 1'b0;
						done_o <= 1'b1;
					end
				end else begin
					pre <= pre - 15'h0001;
				end
			end
		end
	end
endmodule // sgd_timer
`default_nettype wire

// File: logic/sgd_top.v
// sideband glitch generator, line drive override and line monitor with wishbone slave
`timescale 1ns/1ps
`default_nettype none
`include "sgd_defs.vh"
module sgd_top #(
	parameter [14:0] TICK_1MS_CYC = 15'd20000
) (
	input  wire        REF_CLK_I,
	input  wire        SYS_RST_I,
	input  wire        WB_CYC_I,
	input  wire        WB_STB_I,
	input  wire        WB_WE_I,
	input  wire [7:0]  WB_ADR_I,
	input  wire [3:0]  WB_SEL_I,
	input  wire [31:0] WB_DAT_I,
	output reg  [31:0] WB_DAT_O,
	output reg         WB_ACK_O,
	input  wire [5:0]  SWITCH_BASE_I,
	input  wire [5:0]  HOST_LINE_I,
	input  wire [5:0]  DEV_LINE_I,
	output reg  [5:0]  SWITCH_CLOSED_O,
	output reg  [5:0]  DEV_LINE_O,
	output reg  [5:0]  DEV_LINE_OE_N_O,
	output reg         TRIG_OUT_O,
	input  wire        TRIG_IN_I,
	output reg         TRIG_IN_O,
	output reg         TRIG_IN_OE_N_O
);
	localparam [1:0] ST_IDLE  = 2'h0;
	localparam [1:0] ST_PULSE = 2'h1;
	localparam [1:0] ST_GAP   = 2'h2;
	localparam [1:0] ST_SLOT  = 2'h3;
	localparam [5:0] LINE_PUSHPULL = `SGD_PUSHPULL_MASK;

	reg  [1:0]  st;
	reg  [2:0]  mode;
	reg  [17:0] pulse_cfg;
	reg  [17:0] gap_cfg;
	reg  [8:0]  random_glitch_ratio;
	reg  [5:0]  glitch_en;
	reg  [23:0] drive_cfg;
	reg  [12:0] trig_cfg;
	reg  [15:0] lfsr;
	reg         tm_load;
	reg         tm_gap;
	wire        tm_done;
	wire [1:0]  pulse_time_multiplier;
	wire [1:0]  gap_time_multiplier;
	wire [15:0] tm_len;
	wire [1:0]  tm_mult;
	wire [8:0]  ratio_eff;
	wire [15:0] lfsr_mod;
	wire        prbs_hit;
	wire        wb_req;
	wire        wb_wr;
	wire [2:0]  cmd;
	wire        glitch;
	wire [5:0]  next_switch;
	wire [5:0]  next_dev_o;
	wire [5:0]  next_dev_oe_n;
	wire [31:0] wr_pulse;
	wire [31:0] wr_gap;
	wire [31:0] wr_ratio;
	wire [31:0] wr_glen;
	wire [31:0] wr_drive;
	wire [31:0] wr_trig;

	// merge write data into a register under the byte enables
	function [31:0] wmask;
		input [31:0] old;
		input [31:0] wd;
		input [3:0]  sel;
		integer k;
		begin
			wmask = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (sel[k]) begin
					wmask[k*8 +: 8] = wd[k*8 +: 8];
				end
			end
		end
	endfunction

	// pick one monitored line level on the chosen side
	function mon_pick;
		input [2:0] idx;
		input       dev_side;
		input [5:0] host;
		input [5:0] dev;
		begin
			if (idx > 3'h5) begin
				mon_pick = 1'b0;
			end else if (dev_side) begin
				mon_pick = dev[idx];
			end else begin
				mon_pick = host[idx];
			end
		end
	endfunction

	assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	assign wb_wr  = wb_req & WB_WE_I;
	assign cmd    = (wb_wr && WB_ADR_I == `SGD_ADR_CMD && WB_SEL_I[0]) ?
		WB_DAT_I[2:0] : `SGD_CMD_NONE;

	assign pulse_time_multiplier = pulse_cfg[`SGD_MULT_MSB:`SGD_MULT_LSB];
	assign gap_time_multiplier   = gap_cfg[`SGD_MULT_MSB:`SGD_MULT_LSB];
	assign tm_len  = tm_gap ? gap_cfg[`SGD_LEN_MSB:0] : pulse_cfg[`SGD_LEN_MSB:0];
	assign tm_mult = tm_gap ? gap_time_multiplier : pulse_time_multiplier;

	assign wr_pulse = wmask({14'h0000, pulse_cfg}, WB_DAT_I, WB_SEL_I);
	assign wr_gap   = wmask({14'h0000, gap_cfg}, WB_DAT_I, WB_SEL_I);
	assign wr_ratio = wmask({23'h000000, random_glitch_ratio}, WB_DAT_I, WB_SEL_I);
	assign wr_glen  = wmask({26'h0000000, glitch_en}, WB_DAT_I, WB_SEL_I);
	assign wr_drive = wmask({8'h00, drive_cfg}, WB_DAT_I, WB_SEL_I);
	assign wr_trig  = wmask({19'h00000, trig_cfg}, WB_DAT_I, WB_SEL_I);

	// a ratio of zero is treated as one: every slot glitched
	assign ratio_eff = (random_glitch_ratio == 9'h000) ? 9'h001 : random_glitch_ratio;
	assign lfsr_mod  = lfsr % {7'h00, ratio_eff};
	assign prbs_hit  = (lfsr_mod == 16'h0000);

	sgd_timer #(
		.TICK_1MS_CYC (TICK_1MS_CYC)
	) u_timer (
		.clk_i  (REF_CLK_I),
		.rst_i  (SYS_RST_I),
		.load_i (tm_load),
		.mult_i (tm_mult),
		.len_i  (tm_len),
		.done_o (tm_done)
	);

	// free-running lfsr, taps 16,14,13,11
	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			lfsr <= `SGD_LFSR_SEED;
		end else begin
			lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		end
	end

	// timer load strobe; the timer reloads at the same edge the sequencer moves,
	// so a pulse lasts exactly its programmed time
	always @* begin
		tm_load = 1'b0;
		tm_gap  = 1'b0;
		case (cmd)
			`SGD_CMD_ONCE, `SGD_CMD_CYCLE, `SGD_CMD_PRBS: begin
				tm_load = 1'b1;
			end
			`SGD_CMD_OFF: begin
				tm_load = 1'b0;
			end
			default: begin
				if (tm_done) begin
					case (st)
						ST_PULSE: begin
							tm_load = (mode == `SGD_CMD_CYCLE) || (mode == `SGD_CMD_PRBS);
							tm_gap  = (mode == `SGD_CMD_CYCLE);
						end
						ST_GAP, ST_SLOT: begin
							tm_load = 1'b1;
						end
						default: begin
							tm_load = 1'b0;
						end
					endcase
				end
			end
		endcase
	end

	// glitch sequencer; a command beats a timer expiry in the same cycle
	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			st   <= ST_IDLE;
			mode <= `SGD_CMD_NONE;
		end else begin
			case (cmd)
				`SGD_CMD_ONCE: begin
					mode <= `SGD_CMD_ONCE;
					st   <= ST_PULSE;
				end
				`SGD_CMD_CYCLE: begin
					mode <= `SGD_CMD_CYCLE;
					st   <= ST_PULSE;
				end
				`SGD_CMD_PRBS: begin
					mode <= `SGD_CMD_PRBS;
					st   <= prbs_hit ? ST_PULSE : ST_SLOT;
				end
				`SGD_CMD_OFF: begin
					mode <= `SGD_CMD_NONE;
					st   <= ST_IDLE;
				end
				default: begin
					if (tm_done) begin
						case (st)
							ST_PULSE: begin
								if (mode == `SGD_CMD_CYCLE) begin
									st <= ST_GAP;
								end else if (mode == `SGD_CMD_PRBS) begin
									st <= prbs_hit ? ST_PULSE : ST_SLOT;
								end else begin
									st   <= ST_IDLE;
									mode <= `SGD_CMD_NONE;
								end
							end
							ST_GAP: begin
								st <= ST_PULSE;
							end
							ST_SLOT: begin
								st <= prbs_hit ? ST_PULSE : ST_SLOT;
							end
							default: begin
								st <= ST_IDLE;
							end
						endcase
					end
				end
			endcase
		end
	end

	// the expiry cycle already counts as the end of the pulse
	assign glitch = (st == ST_PULSE) && !tm_done;

	// per-line switch state, drive level and enable
	genvar gi;
	generate
		for (gi = 0; gi < `SGD_NLINES; gi = gi + 1) begin : g_line
			wire       closed_eff;
			wire [1:0] set;
			wire       pp;
			assign closed_eff = SWITCH_BASE_I[gi] ^ (glitch & glitch_en[gi]);
			assign set = closed_eff ? drive_cfg[`SGD_DRV_CLOSED_LSB + 2*gi +: 2]
				: drive_cfg[2*gi +: 2];
			assign pp = LINE_PUSHPULL[gi];
			// driving replaces the switch path so the host cannot fight it
			assign next_switch[gi] = closed_eff & (set == `SGD_DRV_NONE);
			assign next_dev_o[gi]  = pp & (set == `SGD_DRV_HIGH);
			assign next_dev_oe_n[gi] = ~((set == `SGD_DRV_LOW) |
				(pp & (set == `SGD_DRV_HIGH)));
		end
	endgenerate

	// host side of every line is input only
	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			SWITCH_CLOSED_O <= 6'h00;
			DEV_LINE_O      <= 6'h00;
			DEV_LINE_OE_N_O <= 6'h3f;
			TRIG_OUT_O      <= 1'b0;
			TRIG_IN_O       <= 1'b0;
			TRIG_IN_OE_N_O  <= 1'b1;
		end else begin
			SWITCH_CLOSED_O <= next_switch;
			DEV_LINE_O      <= next_dev_o;
			DEV_LINE_OE_N_O <= next_dev_oe_n;
			TRIG_OUT_O      <= trig_cfg[4] &
				mon_pick(trig_cfg[2:0], trig_cfg[3], HOST_LINE_I, DEV_LINE_I);
			TRIG_IN_O       <= mon_pick(trig_cfg[`SGD_TRIG_IN_LSB +: 3],
				trig_cfg[`SGD_TRIG_IN_LSB + 3], HOST_LINE_I, DEV_LINE_I);
			// input port only drives in monitor mode; outside gear must be quiet then
			TRIG_IN_OE_N_O  <= ~trig_cfg[`SGD_TRIG_IN_LSB + 4];
		end
	end

	// wishbone register file; write and ack on the same edge
	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			WB_ACK_O            <= 1'b0;
			WB_DAT_O            <= 32'h0000_0000;
			pulse_cfg           <= `SGD_RST_PULSE;
			gap_cfg             <= `SGD_RST_GAP;
			random_glitch_ratio <= `SGD_RST_RATIO;
			glitch_en           <= 6'h00;
			drive_cfg           <= `SGD_RST_DRIVE;
			trig_cfg            <= 13'h0000;
		end else begin
			WB_ACK_O <= wb_req;
			if (wb_wr) begin
				case (WB_ADR_I)
					`SGD_ADR_PULSE: pulse_cfg <= wr_pulse[17:0];
					`SGD_ADR_GAP:   gap_cfg <= wr_gap[17:0];
					`SGD_ADR_RATIO: random_glitch_ratio <= wr_ratio[8:0];
					`SGD_ADR_GLEN:  glitch_en <= wr_glen[5:0];
					`SGD_ADR_DRIVE: drive_cfg <= wr_drive[23:0];
					`SGD_ADR_TRIG:  trig_cfg <= wr_trig[12:0];
					default: begin
					end
				endcase
			end
			if (wb_req) begin
				case (WB_ADR_I)
					`SGD_ADR_CMD:   WB_DAT_O <= {27'h0000000, st, mode};
					`SGD_ADR_PULSE: WB_DAT_O <= {14'h0000, pulse_cfg};
					`SGD_ADR_GAP:   WB_DAT_O <= {14'h0000, gap_cfg};
					`SGD_ADR_RATIO: WB_DAT_O <= {23'h000000, random_glitch_ratio};
					`SGD_ADR_GLEN:  WB_DAT_O <= {26'h0000000, glitch_en};
					`SGD_ADR_DRIVE: WB_DAT_O <= {8'h00, drive_cfg};
					`SGD_ADR_TRIG:  WB_DAT_O <= {19'h00000, trig_cfg};
					`SGD_ADR_MON:   WB_DAT_O <= {15'h0000, TRIG_IN_I, 2'h0, DEV_LINE_I,
						2'h0, HOST_LINE_I};
					default:        WB_DAT_O <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule // sgd_top
`default_nettype wire

// File: test/sgd_lines_model.sv
// far-side model of the host and device sideband lines and the trigger-in pin
`timescale 1ns/1ps
`default_nettype none
module sgd_lines_model (
	input  wire [5:0]  host_lvl_i,
	input  wire [5:0]  sw_i,
	input  wire [5:0]  dev_out_i,
	input  wire [5:0]  dev_oe_n_i,
	input  wire        ext_trig_i,
	input  wire        trig_out_i,
	input  wire        trig_oe_n_i,
	output logic [5:0] host_o,
	output logic [5:0] dev_o,
	output logic       trig_o
);
	// the host alone drives its side; the device side is pulled up when left alone
	always_comb begin
		host_o = host_lvl_i;
		for (int i = 0; i < 6; i++)
			dev_o[i] = !dev_oe_n_i[i] ? dev_out_i[i] : (sw_i[i] ? host_lvl_i[i] : 1'b1);
		// outside equipment lets go of the pin while the block drives it
		trig_o = !trig_oe_n_i ? trig_out_i : ext_trig_i;
	end
endmodule // sgd_lines_model
`default_nettype wire

// File: test/sgd_top_assertions.sv
// port checker for the sideband glitch and drive block
`timescale 1ns/1ps
`default_nettype none
`include "sgd_defs.vh"
module sgd_top_assertions #(
	parameter [14:0] TICK_1MS_CYC = 15'd20000
) (
	input wire        REF_CLK_I,
	input wire        SYS_RST_I,
	input wire        WB_CYC_I,
	input wire        WB_STB_I,
	input wire        WB_WE_I,
	input wire [7:0]  WB_ADR_I,
	input wire [3:0]  WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	input wire [31:0] WB_DAT_O,
	input wire        WB_ACK_O,
	input wire [5:0]  SWITCH_BASE_I,
	input wire [5:0]  HOST_LINE_I,
	input wire [5:0]  DEV_LINE_I,
	input wire [5:0]  SWITCH_CLOSED_O,
	input wire [5:0]  DEV_LINE_O,
	input wire [5:0]  DEV_LINE_OE_N_O,
	input wire        TRIG_OUT_O,
	input wire        TRIG_IN_I,
	input wire        TRIG_IN_O,
	input wire        TRIG_IN_OE_N_O
);
	logic [5:0]  glen;
	logic [23:0] drv;
	logic [12:0] trig;
	logic [5:0]  nodrv;
	wire         take = WB_CYC_I & WB_STB_I & WB_WE_I & ~WB_ACK_O & (WB_SEL_I == 4'hf);
	wire  [2:0]  oi = (trig[2:0] > 3'h5) ? 3'h0 : trig[2:0];
	wire         lvl = (trig[2:0] > 3'h5) ? 1'b0 : (trig[3] ? DEV_LINE_I[oi] : HOST_LINE_I[oi]);
	// shadow of the registers that shape the outputs
	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			glen <= 6'h00;
			drv <= 24'h000000;
			trig <= 13'h0000;
		end else if (take) begin
			if (WB_ADR_I == `SGD_ADR_GLEN)
				glen <= WB_DAT_I[5:0];
			if (WB_ADR_I == `SGD_ADR_DRIVE)
				drv <= WB_DAT_I[23:0];
			if (WB_ADR_I == `SGD_ADR_TRIG)
				trig <= WB_DAT_I[12:0];
		end
	end
	always_comb begin
		for (int i = 0; i < 6; i++)
			nodrv[i] = (drv[2*i] == drv[2*i+1]) && (drv[12+2*i] == drv[13+2*i]);
	end
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	AST_ACK_ONE_CYCLE: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held too long");
	AST_ACK_AFTER_TAKE: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("request not acknowledged");
	AST_SWITCH_FOLLOWS: assert property (!$past(SYS_RST_I) |->
		((SWITCH_CLOSED_O ^ $past(SWITCH_BASE_I)) & $past(~glen & nodrv)) == 6'h00)
		else $error("switch left its base state");
	AST_NODRIVE_RELEASED: assert property ((~DEV_LINE_OE_N_O & $past(nodrv)) == 6'h00)
		else $error("line driven with no drive setting");
	AST_OPEN_DRAIN_LOW: assert property ((~DEV_LINE_OE_N_O & DEV_LINE_O & 6'h1c) == 6'h00)
		else $error("open-drain line driven high");
	AST_DRIVE_OPENS: assert property ((~DEV_LINE_OE_N_O & SWITCH_CLOSED_O) == 6'h00)
		else $error("line driven through a closed switch");
	AST_PP_HIGH: assert property ($past(!SWITCH_BASE_I[5] && drv[11:10] == 2'h1 && !glen[5]) |->
		!DEV_LINE_OE_N_O[5] && DEV_LINE_O[5])
		else $error("push-pull line not driven high");
	AST_TRIG_OUT_MIRROR: assert property (TRIG_OUT_O == $past(trig[4] & lvl))
		else $error("trigger out does not mirror");
	AST_TRIG_IN_MODE: assert property (TRIG_IN_OE_N_O == !$past(trig[12]))
		else $error("trigger in enable wrong");
	AST_MON_READ: assert property (WB_ACK_O && $past(WB_ADR_I == `SGD_ADR_MON && !WB_WE_I) |->
		WB_DAT_O[16:0] == $past({TRIG_IN_I, 2'b00, DEV_LINE_I, 2'b00, HOST_LINE_I}))
		else $error("level report wrong");
	cover property ($rose(TRIG_OUT_O));
	cover property ($fell(TRIG_IN_OE_N_O));
	cover property (!DEV_LINE_OE_N_O[0] && !DEV_LINE_O[0]);
endmodule // sgd_top_assertions
bind sgd_top sgd_top_assertions #(.TICK_1MS_CYC(TICK_1MS_CYC)) i_sgd_chk (
	.REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
	.WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
	.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SWITCH_BASE_I(SWITCH_BASE_I),
	.HOST_LINE_I(HOST_LINE_I), .DEV_LINE_I(DEV_LINE_I), .SWITCH_CLOSED_O(SWITCH_CLOSED_O),
	.DEV_LINE_O(DEV_LINE_O), .DEV_LINE_OE_N_O(DEV_LINE_OE_N_O), .TRIG_OUT_O(TRIG_OUT_O),
	.TRIG_IN_I(TRIG_IN_I), .TRIG_IN_O(TRIG_IN_O), .TRIG_IN_OE_N_O(TRIG_IN_OE_N_O));
`default_nettype wire

// File: test/sideband_glitch_and_drive_control_tb_top.sv
// self-checking bench for the sideband glitch and drive block
`timescale 1ns/1ps
`default_nettype none
`include "sgd_defs.vh"
module sideband_glitch_and_drive_control_tb_top;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'hf;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [5:0]  base = 6'h00;
	logic [5:0]  host_lvl = 6'h3f;
	logic        ext_trig = 1'b0;
	wire  [31:0] dat_o;
	wire  [5:0]  host_line, dev_line, sw, dev_o, dev_oe_n;
	wire         ack, trig_out, trig_in, trig_in_o, trig_in_oe_n;
	int          fail_count = 0;
	int          n_compared = 0;
	int          cycles = 0;
	int          n;
	int          hi;
	always #25 clk = ~clk;
	sgd_top #(.TICK_1MS_CYC(15'd20)) i_dut (
		.REF_CLK_I(clk), .SYS_RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
		.SWITCH_BASE_I(base), .HOST_LINE_I(host_line), .DEV_LINE_I(dev_line),
		.SWITCH_CLOSED_O(sw), .DEV_LINE_O(dev_o), .DEV_LINE_OE_N_O(dev_oe_n),
		.TRIG_OUT_O(trig_out), .TRIG_IN_I(trig_in), .TRIG_IN_O(trig_in_o),
		.TRIG_IN_OE_N_O(trig_in_oe_n));
	sgd_lines_model i_lines (
		.host_lvl_i(host_lvl), .sw_i(sw), .dev_out_i(dev_o), .dev_oe_n_i(dev_oe_n),
		.ext_trig_i(ext_trig), .trig_out_i(trig_in_o), .trig_oe_n_i(trig_in_oe_n),
		.host_o(host_line), .dev_o(dev_line), .trig_o(trig_in));
	task print_verdict;
		if (fail_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// one classic cycle, entered and left just after a rising edge
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		k = 0;
		@(posedge clk);
		while (ack !== 1'b1 && k < 20) begin
			@(posedge clk);
			k++;
		end
		chk(k < 20, 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask
	// length of the run of one level on switch 0 or on drive enable 0
	task meas(input logic pick, input logic lvl, output int len);
		len = 0;
		while ((pick ? dev_oe_n[0] : sw[0]) === lvl && len < 3000) begin
			@(posedge clk);
			len++;
		end
	endtask
	task t_reset_map;
		rd(`SGD_ADR_PULSE, 32'h1);
		rd(`SGD_ADR_GAP, 32'h1);
		rd(`SGD_ADR_RATIO, 32'h2);
		rd(`SGD_ADR_GLEN, 32'h0);
		rd(`SGD_ADR_DRIVE, 32'h0);
		wb(1'b1, 8'h20, 32'hffff_ffff);
		rd(8'h20, 32'h0);
		base <= 6'h3f;
		host_lvl <= 6'h2a;
		repeat (3) @(posedge clk);
		rd(`SGD_ADR_MON, 32'h0000_2a2a);
	endtask
	task t_once;
		base <= 6'h00;
		wb(1'b1, `SGD_ADR_PULSE, 32'h3);
		wb(1'b1, `SGD_ADR_GLEN, 32'h1);
		wb(1'b1, `SGD_ADR_CMD, 32'h1);
		meas(1'b0, 1'b0, n);
		meas(1'b0, 1'b1, n);
		chk(n, 60);
		meas(1'b0, 1'b0, n);
		chk(n, 3000);
		wb(1'b1, `SGD_ADR_CMD, 32'h1);
		meas(1'b0, 1'b0, n);
		meas(1'b0, 1'b1, n);
		chk(n, 60);
	endtask
	task t_cycle;
		wb(1'b1, `SGD_ADR_PULSE, 32'h1);
		wb(1'b1, `SGD_ADR_GAP, 32'h2);
		wb(1'b1, `SGD_ADR_CMD, 32'h2);
		meas(1'b0, 1'b0, n);
		repeat (2) begin
			meas(1'b0, 1'b1, n);
			chk(n, 20);
			meas(1'b0, 1'b0, n);
			chk(n, 42);
		end
		wb(1'b1, `SGD_ADR_CMD, 32'h4);
		meas(1'b0, 1'b1, n);
		meas(1'b0, 1'b0, n);
		chk(n, 3000);
	endtask
	task t_prbs;
		wb(1'b1, `SGD_ADR_CMD, 32'h3);
		for (int r = 2; r > 0; r--) begin
			wb(1'b1, `SGD_ADR_RATIO, r);
			hi = 0;
			repeat (4400) begin
				@(posedge clk);
				hi += sw[0];
			end
			chk(r == 2 ? (hi > 1200 && hi < 2800) : (hi > 3600), 1'b1);
		end
		wb(1'b1, `SGD_ADR_CMD, 32'h4);
		meas(1'b0, 1'b1, n);
		meas(1'b0, 1'b0, n);
		chk(n, 3000);
		wb(1'b1, `SGD_ADR_RATIO, 32'h100);
		rd(`SGD_ADR_RATIO, 32'h100);
	endtask
	task t_drive;
		base <= 6'h01;
		wb(1'b1, `SGD_ADR_DRIVE, 32'h2490);
		repeat (3) @(posedge clk);
		chk(sw, 6'h00);
		chk(dev_oe_n, 6'h16);
		chk(dev_o & ~dev_oe_n, 6'h20);
		wb(1'b1, `SGD_ADR_DRIVE, 32'h2);
		repeat (3) @(posedge clk);
		chk({sw, dev_oe_n}, 12'h07f);
		wb(1'b1, `SGD_ADR_CMD, 32'h1);
		meas(1'b1, 1'b1, n);
		meas(1'b1, 1'b0, n);
		chk(n, 20);
		wb(1'b1, `SGD_ADR_DRIVE, 32'h0);
		wb(1'b1, `SGD_ADR_CMD, 32'h1);
		meas(1'b0, 1'b1, n);
		meas(1'b0, 1'b0, n);
		chk(n, 20);
	endtask
	task t_trig;
		base <= 6'h3f;
		host_lvl <= 6'h08;
		wb(1'b1, `SGD_ADR_TRIG, 32'h150b);
		repeat (3) @(posedge clk);
		chk({trig_out, trig_in_oe_n}, 2'b00);
		wb(1'b1, `SGD_ADR_TRIG, 32'h151b);
		repeat (3) @(posedge clk);
		chk({trig_out, trig_in_o}, 2'b10);
		host_lvl <= 6'h20;
		repeat (3) @(posedge clk);
		chk({trig_out, trig_in_o}, 2'b01);
		rd(`SGD_ADR_MON, 32'h0001_2020);
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fail_count++;
			print_verdict;
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset_map;
		t_once;
		t_cycle;
		t_prbs;
		t_drive;
		t_trig;
		print_verdict;
	end
endmodule // sideband_glitch_and_drive_control_tb_top
`default_nettype wire
